// ===== src/usfpid_map.svh
// register map, field positions and timing constants of the serial block
// Notes on behaviour
// R1: wake field: 0 idle line, 1 address mark.
// R2: idle count starts after start or stop.
// R3: start-bit counting tallies data ones too.
// R4: stop-bit counting: zero shifted after stop.
// R5: parity on enables generation and checking.
// R6: parity bit sits just before stop.
// R7: parity type: 0 even, 1 odd.
// R8: data read is rx buffer, write tx.
// R9: data accesses clear status flags automatically.
// R10: data bits 31..16 read zero.
// R11: data bit 15 is noise flag.
// R12: data bit 14 is parity fault flag.
// R13: wake method matters only in standby.
// R14: bit 13: frame fault; write sends special.
// R15: length select: 0 eight, 1 nine bits.
// R16: parity mismatch raises parity fault flag.
`ifndef USFPID_MAP_SVH
`define USFPID_MAP_SVH
`define USF_ADDR_CTRL      4'h0
`define USF_ADDR_DATA      4'h4
`define USF_ADDR_STAT      4'h8
`define USF_ADDR_MASK      4'hC
`define USF_CTRL_PT        0
`define USF_CTRL_PE        1
`define USF_CTRL_ILT       2
`define USF_CTRL_WAKE      3
`define USF_CTRL_M         4
`define USF_CTRL_RWU       5
`define USF_CTRL_TE        6
`define USF_CTRL_RE        7
`define USF_DATA_NOISE     15
`define USF_DATA_PAR       14
`define USF_DATA_FRM       13
`define USF_DATA_EMPTY     12
`define USF_ST_RXFULL      0
`define USF_ST_TXDONE      1
`define USF_ST_IDLE        2
`define USF_ST_PERR        3
`define USF_ST_FERR        4
`define USF_ST_OVR         5
`define USF_ST_W           6
`define USF_CTRL_RST       8'h00
`define USF_BAUD_DIV       16'h0010
`define USF_IDLE_BITS      4'hA
`endif

// ===== src/usfpid_pkg.sv
// types shared by the serial block
`default_nettype none
package usfpid_pkg;
   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } usf_bus_t;
   typedef enum logic [1:0] {S_IDLE, S_START, S_BITS, S_STOP} usf_state_t;
endpackage
`default_nettype wire

// ===== src/usfpid_top.sv
// serial transceiver with parity, idle detection, standby and data register
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`include "usfpid_map.svh"
`default_nettype none
module usfpid_top
   import usfpid_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_n_i,
   // register port
   input  wire logic [3:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   // serial line and interrupt
   input  wire logic        rx_i,
   output logic             tx_o,
   output logic             irq_o
);
   usf_bus_t bus;
   assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

   // pin synchroniser
   logic rx_m, rx_s;
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_m <= 1'b1;
         rx_s <= 1'b1;
      end else begin
         rx_m <= rx_i;
         rx_s <= rx_m;
      end
   end

   logic [7:0]  ctrl, next_ctrl;
   logic [5:0]  stat, next_stat, mask, next_mask;
   logic [31:0] rdata, next_rdata;
   logic        irq, next_irq;
   wire  wr_data = bus.wr && bus.addr == `USF_ADDR_DATA;
   wire  rd_data = bus.rd && bus.addr == `USF_ADDR_DATA;
   wire  nine = ctrl[`USF_CTRL_M];                                 // [R15]
   wire  par_on = ctrl[`USF_CTRL_PE];                              // [R5]
   wire  par_odd = ctrl[`USF_CTRL_PT];                             // [R7]
   wire [3:0] nbits = 4'h8 + {3'h0, nine} + {3'h0, par_on};        // [R6]

   // ---------------- transmitter ----------------
   usf_state_t  t_st, next_t_st;
   logic [15:0] t_cnt, next_t_cnt;
   logic [3:0]  t_idx, next_t_idx;
   logic [10:0] t_sh, next_t_sh;
   logic        t_spc, next_t_spc, t_pend, next_t_pend;
   logic [9:0]  t_buf, next_t_buf;
   logic        tx, next_tx, t_done;
   always_comb begin
      next_t_st = t_st;
      next_t_cnt = t_cnt;
      next_t_idx = t_idx;
      next_t_sh = t_sh;
      next_t_spc = t_spc;
      next_t_pend = t_pend;
      next_t_buf = t_buf;
      next_tx = tx;
      t_done = 1'b0;
      if (wr_data) begin                                          // [R8]
         next_t_buf = bus.wdata[9:0];
         next_t_spc = bus.wdata[`USF_DATA_FRM];                    // [R14]
         next_t_pend = 1'b1;
      end
      case (t_st)
         S_IDLE: begin
            next_tx = 1'b1;
            if (t_pend && ctrl[`USF_CTRL_TE]) begin
               next_t_pend = wr_data;
               next_t_st = S_START;
               next_t_cnt = `USF_BAUD_DIV;
               next_t_idx = 4'h0;
               next_t_sh = 11'h7FF;
               if (!t_spc) begin
                  next_t_sh[8:0] = t_buf[8:0];
                  if (!nine)
                     next_t_sh[8] = 1'b1;
                  // parity before stop, even/odd     [R5] [R6] [R7]
                  if (par_on)
                     next_t_sh[nbits - 4'h1] = par_odd ^
                        (^(t_buf[8:0] & (nine ? 9'h1FF : 9'h0FF)));
               end else if (!t_buf[9])
                  next_t_sh = 11'h000;                            // [R14]
               next_tx = t_spc && t_buf[9];
            end
         end
         S_START: begin
            next_t_cnt = t_cnt - 16'h1;
            if (t_cnt == 16'h1) begin
               next_t_cnt = `USF_BAUD_DIV;
               next_t_st = S_BITS;
               next_tx = t_sh[0];
            end
         end
         S_BITS: begin
            next_t_cnt = t_cnt - 16'h1;
            if (t_cnt == 16'h1) begin
               next_t_cnt = `USF_BAUD_DIV;
               next_t_sh = {1'b1, t_sh[10:1]};
               next_t_idx = t_idx + 4'h1;
               next_tx = t_sh[1];
               if (t_idx == nbits - 4'h1) begin
                  next_t_st = S_STOP;
                  next_tx = ~(t_spc && !t_buf[9]) ;
               end
            end
         end
         S_STOP: begin
            next_t_cnt = t_cnt - 16'h1;
            if (t_cnt == 16'h1) begin
               next_t_st = S_IDLE;
               next_tx = 1'b1;
               t_done = 1'b1;
            end
         end
         default: next_t_st = S_IDLE;
      endcase
   end
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         t_st <= S_IDLE;
         t_cnt <= 16'h0;
         t_idx <= 4'h0;
         t_sh <= 11'h7FF;
         t_spc <= 1'b0;
         t_pend <= 1'b0;
         t_buf <= 10'h0;
         tx <= 1'b1;
      end else begin
         t_st <= next_t_st;
         t_cnt <= next_t_cnt;
         t_idx <= next_t_idx;
         t_sh <= next_t_sh;
         t_spc <= next_t_spc;
         t_pend <= next_t_pend;
         t_buf <= next_t_buf;
         tx <= next_tx;
      end
   end

   // ---------------- receiver ----------------
   usf_state_t  r_st, next_r_st;
   logic [15:0] r_cnt, next_r_cnt;
   logic [3:0]  r_idx, next_r_idx;
   logic [10:0] r_sh, next_r_sh;
   logic [3:0]  idle_cnt, next_idle_cnt;
   logic        r_noise, next_r_noise, prev_rx, standby, next_standby;
   logic [12:0] rbuf, next_rbuf;  // noise, parity, frame, data[9:0]
   logic        rfull, next_rfull;
   logic        ev_rx, ev_idle, ev_ovr;
   logic        par_bad;
   always_comb begin
      next_r_st = r_st;
      next_r_cnt = r_cnt;
      next_r_idx = r_idx;
      next_r_sh = r_sh;
      next_idle_cnt = idle_cnt;
      next_r_noise = r_noise;
      next_rbuf = rbuf;
      next_rfull = rfull && !rd_data;                              // [R9]
      next_standby = standby;
      ev_rx = 1'b0;
      ev_idle = 1'b0;
      ev_ovr = 1'b0;
      par_bad = 1'b0;
      if (bus.wr && bus.addr == `USF_ADDR_CTRL)
         next_standby = bus.wdata[`USF_CTRL_RWU];                  // [R13]
      case (r_st)
         S_IDLE: begin
            next_r_cnt = r_cnt - 16'h1;
            if (r_cnt == 16'h1) begin
               next_r_cnt = `USF_BAUD_DIV;
               // count ones toward an idle character        [R2] [R3]
               if (rx_s && idle_cnt != `USF_IDLE_BITS) begin
                  next_idle_cnt = idle_cnt + 4'h1;
                  if (idle_cnt == `USF_IDLE_BITS - 4'h1) begin
                     ev_idle = 1'b1;
                     if (standby && !ctrl[`USF_CTRL_WAKE])
                        next_standby = 1'b0;                       // [R1]
                  end
               end
            end
            if (!rx_s && prev_rx && ctrl[`USF_CTRL_RE]) begin
               next_r_st = S_START;
               next_r_cnt = `USF_BAUD_DIV >> 1;
               next_r_noise = 1'b0;
               if (!ctrl[`USF_CTRL_ILT])
                  next_idle_cnt = 4'h0;                            // [R2]
            end
         end
         S_START: begin
            next_r_cnt = r_cnt - 16'h1;
            if (r_cnt == 16'h1) begin
               next_r_cnt = `USF_BAUD_DIV;
               next_r_idx = 4'h0;
               if (rx_s) next_r_st = S_IDLE; else next_r_st = S_BITS;
            end
         end
         S_BITS: begin
            next_r_cnt = r_cnt - 16'h1;
            if (r_cnt == 16'h1) begin
               next_r_cnt = `USF_BAUD_DIV;
               next_r_sh[r_idx] = rx_s;
               next_r_idx = r_idx + 4'h1;
               if (!ctrl[`USF_CTRL_ILT]) begin                     // [R3]
                  if (rx_s) next_idle_cnt = idle_cnt + 4'h1;
                  else next_idle_cnt = 4'h0;
               end
               if (r_idx == nbits - 4'h1) next_r_st = S_STOP;
            end else if (r_cnt == (`USF_BAUD_DIV >> 1) - 16'h1 &&
                         rx_s != prev_rx)
               next_r_noise = 1'b1;                                // [R11]
         end
         S_STOP: begin
            next_r_cnt = r_cnt - 16'h1;
            if (r_cnt == 16'h1) begin
               next_r_cnt = `USF_BAUD_DIV;
               next_r_st = S_IDLE;
               // zero shifted after stop clears the tally           [R4]
               // counting from the start bit lets the stop bit count [R3]
               if (ctrl[`USF_CTRL_ILT] || !rx_s)
                  next_idle_cnt = 4'h0;
               else if (idle_cnt != `USF_IDLE_BITS)
                  next_idle_cnt = idle_cnt + 4'h1;
               // parity mismatch check              [R7] [R16] [R12]
               par_bad = par_on && (par_odd ^
                  (^(r_sh[9:0] & (10'h3FF >> (4'hA - nbits)))));
               if (standby && ctrl[`USF_CTRL_WAKE] &&
                   r_sh[nbits - 4'h1 - {3'h0, par_on}])
                  next_standby = 1'b0;                             // [R1]
               if (!next_standby) begin                            // [R13]
                  ev_rx = 1'b1;
                  ev_ovr = rfull && !rd_data;
                  next_rfull = 1'b1;
                  next_rbuf[12] = r_noise;
                  next_rbuf[11] = par_bad;
                  next_rbuf[10] = !rx_s;                           // [R14]
                  next_rbuf[9:0] = r_sh[9:0] & (nine ? 10'h1FF : 10'h0FF);
                  if (par_on) next_rbuf[nbits - 4'h1] = 1'b0;
               end
            end
         end
         default: next_r_st = S_IDLE;
      endcase
   end
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r_st <= S_IDLE;
         r_cnt <= `USF_BAUD_DIV;
         r_idx <= 4'h0;
         r_sh <= 11'h0;
         idle_cnt <= 4'h0;
         r_noise <= 1'b0;
         prev_rx <= 1'b1;
         rbuf <= 13'h0;
         rfull <= 1'b0;
         standby <= 1'b0;
      end else begin
         r_st <= next_r_st;
         r_cnt <= next_r_cnt;
         r_idx <= next_r_idx;
         r_sh <= next_r_sh;
         idle_cnt <= next_idle_cnt;
         r_noise <= next_r_noise;
         prev_rx <= rx_s;
         rbuf <= next_rbuf;
         rfull <= next_rfull;
         standby <= next_standby;
      end
   end

   // ---------------- registers and interrupt ----------------
   logic [5:0] ev;
   always_comb begin
      ev = 6'h0;
      ev[`USF_ST_RXFULL] = ev_rx;
      ev[`USF_ST_TXDONE] = t_done;
      ev[`USF_ST_IDLE] = ev_idle;
      ev[`USF_ST_PERR] = par_bad;
      ev[`USF_ST_FERR] = ev_rx && next_rbuf[10];
      ev[`USF_ST_OVR] = ev_ovr;
      next_ctrl = ctrl;
      next_mask = mask;
      next_stat = stat;
      next_rdata = 32'h0;
      if (bus.wr && bus.addr == `USF_ADDR_CTRL) begin
         next_ctrl = bus.wdata[7:0];
         next_ctrl[`USF_CTRL_RWU] = 1'b0;  // shown from live standby
      end
      if (bus.wr && bus.addr == `USF_ADDR_MASK)
         next_mask = bus.wdata[5:0];
      if (bus.wr && bus.addr == `USF_ADDR_STAT)
         next_stat = stat & ~bus.wdata[5:0];
      if (rd_data)                                                 // [R9]
         next_stat[`USF_ST_RXFULL] = 1'b0;
      if (wr_data)                                                 // [R9]
         next_stat[`USF_ST_TXDONE] = 1'b0;
      next_stat = next_stat | ev;   // a new event beats the clear
      if (bus.rd) begin
         case (bus.addr)
            `USF_ADDR_CTRL: begin
               next_rdata[7:0] = ctrl;
               next_rdata[`USF_CTRL_RWU] = standby;
            end
            // upper half stays zero            [R8] [R10] [R11] [R12]
            `USF_ADDR_DATA: next_rdata[15:0] = {rbuf[12:10], !rfull,
                                                2'b00, rbuf[9:0]};
            `USF_ADDR_STAT: next_rdata[5:0] = stat;
            `USF_ADDR_MASK: next_rdata[5:0] = mask;
            default: next_rdata = 32'h0;
         endcase
      end
      next_irq = |(next_stat & next_mask);
   end
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl <= `USF_CTRL_RST;
         mask <= 6'h0;
         stat <= 6'h0;
         rdata <= 32'h0;
         irq <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         mask <= next_mask;
         stat <= next_stat;
         rdata <= next_rdata;
         irq <= next_irq;
      end
   end
   assign rdata_o = rdata;
   assign tx_o = tx;
   assign irq_o = irq;

   AST_RDZERO: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      rdata_o[31:16] == 16'h0000) else $error("data upper bits nonzero"); // [R10]
   AST_EMPTY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      rd_data |=> rdata_o[`USF_DATA_EMPTY] == !$past(rfull))
      else $error("empty bit wrong"); // [R8]
   AST_RDCLR: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      rd_data && !ev_rx |=> !rfull) else $error("read did not clear"); // [R9]
   AST_NOPAR: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !par_on |-> !par_bad) else $error("parity fault while off"); // [R5]
   AST_ILT1: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      r_st == S_STOP && next_r_st == S_IDLE && ctrl[`USF_CTRL_ILT]
      |=> idle_cnt == 4'h0)
      else $error("idle tally not cleared"); // [R4]
   AST_STANDBY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      standby && next_standby |-> !ev_rx) else $error("rx in standby"); // [R13]
   AST_PFLAG: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      ev_rx |=> rbuf[11] == $past(par_bad)) else $error("parity flag"); // [R12]
   AST_IRQ: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      ##1 irq_o == |($past(next_stat) & $past(next_mask)))
      else $error("irq mismatch");
   COV_RX: cover property (@(posedge sys_clk_i) ev_rx);
   COV_PERR: cover property (@(posedge sys_clk_i) par_bad);
   COV_IDLE: cover property (@(posedge sys_clk_i) ev_idle);
   COV_TX: cover property (@(posedge sys_clk_i) t_done);
endmodule
`default_nettype wire

// ===== dv/usfpid_remote.sv
// remote serial end: drives the receive line, decodes the transmit line
`default_nettype none
module usfpid_remote #(
   parameter int BITCLK = 16
) (
   // clock
   input  wire logic clk_i,
   // serial lines
   input  wire logic line_i,
   output logic      line_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] got;
   int         got_n = 0;

   initial line_o = 1'b1;

   // stp low forges a frame error; the line idles high between frames
   task automatic send(input logic [7:0] d, input logic pe,
                       input logic par, input logic stp);
      logic [10:0] f;
      f = pe ? {stp, par, d, 1'b0} : {1'b1, stp, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         line_o <= f[i]; // lsb first, parity just before stop
         repeat (BITCLK) @(posedge clk_i);
      end
      line_o <= 1'b1;
   endtask

   // mid-bit sampling of data, then parity or stop, then one more bit
   always begin
      @(negedge line_i);
      repeat (BITCLK / 2) @(posedge clk_i);
      for (int i = 0; i < 10; i++) begin
         repeat (BITCLK) @(posedge clk_i);
         got[i] = line_i;
      end
      got_n++;
   end
endmodule
`default_nettype wire

// ===== dv/test_usfpid_top.sv
// self-checking bench of the serial block against a remote serial model
`include "usfpid_map.svh"
`default_nettype none
module test_usfpid_top
   import usfpid_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk;
   logic        rst_n;
   logic        rx;
   logic        tx;
   logic        irq;
   logic        rd_d = 1'b0;
   usf_bus_t    bus;
   logic [31:0] rdata;
   logic [31:0] seed = 32'hEF96;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   int          err_count = 0;
   int          checks_done = 0;

   usfpid_top uut (.sys_clk_i(clk), .rst_n_i(rst_n), .addr_i(bus.addr),
      .wdata_i(bus.wdata), .wr_i(bus.wr), .rd_i(bus.rd), .rdata_o(rdata),
      .rx_i(rx), .tx_o(tx), .irq_o(irq));
   usfpid_remote rem (.clk_i(clk), .line_i(tx), .line_o(rx));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   // expectation is queued here and judged by the watcher below
   task automatic rd(input logic [3:0] a, input logic [31:0] e,
                     input logic [31:0] m);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      @(posedge clk);
      bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
   endtask

   always @(posedge clk) begin
      if (rd_d) check("rdata", rdata & msk_q.pop_front(), exp_q.pop_front());
      rd_d <= bus.rd;
   end

   task automatic wait_frame(input int n0);
      int k;
      k = 0;
      while (rem.got_n == n0 && k < 400) begin
         @(posedge clk);
         k++;
      end
      repeat (16) @(posedge clk);
      check("tx frame seen", {31'h0, k < 400}, 32'h1);
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      end_sim();
   end

   initial begin
      logic [7:0] d;
      logic       p;
      int         n;
      int         k;
      bus = '0;
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(`USF_ADDR_CTRL, {24'h0, `USF_CTRL_RST}, 32'hFFFF_FFFF);
      rd(`USF_ADDR_DATA, 32'h0000_1000, 32'hFFFF_F000);
      rd(4'h2, 32'h0000_0000, 32'hFFFF_FFFF);
      $display("test reset and unmapped done");
      // every parity on/type pair, random characters
      for (int m = 0; m < 4; m++) begin
         seed = lfsr(seed);
         d = seed[7:0];
         wr(`USF_ADDR_CTRL, {24'h0, 6'h30, m[1:0]});
         n = rem.got_n;
         wr(`USF_ADDR_DATA, {24'h0, d});
         wait_frame(n);
         check("tx data", {24'h0, rem.got[7:0]}, {24'h0, d});
         p = m[1] ? (^d ^ m[0]) : 1'b1;
         check("tx tail", {30'h0, rem.got[9:8]}, {30'h0, 1'b1, p});
      end
      $display("test transmit parity done");
      // only parity faults reach the interrupt
      wr(`USF_ADDR_MASK, 32'h0000_0008);
      for (int m = 0; m < 6; m++) begin
         seed = lfsr(seed);
         d = seed[7:0];
         k = m / 2;
         wr(`USF_ADDR_CTRL, {24'h0, 7'h61, m[0]});
         wr(`USF_ADDR_STAT, 32'h0000_003F);
         p = ^d ^ m[0] ^ (k == 1);
         rem.send(d, 1'b1, p, k != 2);
         repeat (24) @(posedge clk);
         check("irq", {31'h0, irq}, {31'h0, k == 1});
         rd(`USF_ADDR_STAT, {26'h0, 1'b0, k == 2, k == 1, 3'b001},
            32'h0000_0039);
         rd(`USF_ADDR_DATA, {16'h0, 1'b0, k == 1, k == 2, 5'h0, d},
            32'hFFFF_F3FF);
         rd(`USF_ADDR_STAT, 32'h0000_0000, 32'h0000_0001);
         wr(`USF_ADDR_STAT, 32'h0000_0008);
         repeat (3) @(posedge clk);
         check("irq cleared", {31'h0, irq}, 32'h0);
      end
      $display("test receive parity and frame done");
      // standby with address-mark wake ignores a plain character
      wr(`USF_ADDR_CTRL, 32'h0000_00E8);
      wr(`USF_ADDR_STAT, 32'h0000_003F);
      seed = lfsr(seed);
      rem.send({1'b0, seed[6:0]}, 1'b0, 1'b0, 1'b1);
      repeat (24) @(posedge clk);
      rd(`USF_ADDR_STAT, 32'h0000_0000, 32'h0000_0001);
      rem.send({1'b1, seed[6:0]}, 1'b0, 1'b0, 1'b1);
      repeat (24) @(posedge clk);
      rd(`USF_ADDR_STAT, 32'h0000_0001, 32'h0000_0001);
      repeat (200) @(posedge clk);
      rd(`USF_ADDR_STAT, 32'h0000_0004, 32'h0000_0004);
      $display("test standby wake done");
      repeat (4) @(posedge clk);
      end_sim();
   end
endmodule
`default_nettype wire
